// ==== host_port_model.sv ====
`timescale 1ns/1ps
// ************************************************************
// host processor: serial port master and reset pin
// ************************************************************
module host_port_model (
  input wire logic clock, // system clock, for pacing only
  input wire logic sdo, // serial data from the device
  input wire logic sdo_oe, // device drive enable on serial data
  output logic reset_pin_n, // device reset, active low
  output logic spi_sclk, // serial clock, still outside frames
  output logic spi_cs_n, // chip select, active low
  output logic serial_in // serial data to the device
);
  localparam int HALF = 4; // 100 ns half period of the link clock

  // idle levels at time zero
  initial begin
    reset_pin_n = 1'b1;
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    serial_in = 1'b0;
  end

  // reset pulse; the hold length is shortened for the run
  task automatic pulse_reset(input int hold);
    @(negedge clock);
    reset_pin_n = 1'b0;
    repeat (hold) @(negedge clock);
    reset_pin_n = 1'b1;
  endtask

  // one 16-bit frame, msb first; data changes on fall, read on rise
  task automatic xfer(input logic [7:0] cmd, input logic [7:0] wd,
                      output logic [7:0] rd, output logic oe_all);
    logic [15:0] sh;
    int i;
    sh = {cmd, wd};
    rd = 8'h00;
    oe_all = 1'b1;
    @(negedge clock);
    spi_cs_n = 1'b0;
    for (i = 15; i >= 0; i--) begin
      serial_in = sh[i];
      repeat (HALF) @(negedge clock);
      if (i < 8) begin
        rd = {rd[6:0], sdo};
      end
      oe_all = oe_all & (sdo_oe === 1'b1);
      spi_sclk = 1'b1;
      repeat (HALF) @(negedge clock);
      spi_sclk = 1'b0;
    end
    repeat (HALF) @(negedge clock);
    spi_cs_n = 1'b1;
    // released data line shows the inverse of its last value
    serial_in = ~serial_in;
  endtask
endmodule

// ==== osd_defines.svh ====
`ifndef OSD_DEFINES_SVH
`define OSD_DEFINES_SVH

// ************************************************************
// timing
// ************************************************************
`define CLK_PERIOD_NS 25
`define LINE_PERIOD_NS 64000
`define LINE_CYC (`LINE_PERIOD_NS / `CLK_PERIOD_NS)
`define LINE_WINDOW_NS 80000
`define LINE_WINDOW_CYC (`LINE_WINDOW_NS / `CLK_PERIOD_NS)
`define BROAD_MIN_NS 10000
`define BROAD_MIN_CYC ((`BROAD_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define LINE_PULSE_NS 4700
`define LINE_PULSE_CYC \
  ((`LINE_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FRAME_PULSE_LINES 3
`define FIELD_LINES 312
`define SYNC_RUN_LINES 32
`define REG_ACCESS_NS 100000
`define REG_ACCESS_CYC (`REG_ACCESS_NS / `CLK_PERIOD_NS)
`define MEM_CLEAR_NS 20000
`define MEM_CLEAR_CYC (`MEM_CLEAR_NS / `CLK_PERIOD_NS)

// ************************************************************
// memory and register map
// ************************************************************
`define MEM_DEPTH 480
`define MEM_CLEAR_VALUE 8'h00
`define REG_MODE 7'h00
`define REG_ADDR_LO 7'h01
`define REG_ADDR_HI 7'h02
`define REG_DATA 7'h03
`define REG_STATUS 7'h04
`define MODE_RESET 8'h00
`define MODE_INT_BIT 0
`define CMD_READ_BIT 7

`endif

// ==== osd_pin_level_control.sv ====
`timescale 1ns/1ps
// Notes on behaviour
// RQ1 - serial output floats while chip select is high, driven while low
// RQ2 - serial input bits are taken on each rising serial clock edge
// RQ3 - serial output moves on falling serial clock edge
// RQ4 - loss flag rises after 32 consecutive line periods without sync
// RQ5 - loss flag falls only after 32 consecutive valid sync pulses
// RQ6 - frame sync output pulls low after the vertical sync interval
// RQ7 - line sync output pulls low after the horizontal sync interval
// RQ8 - sync outputs follow video input, or timing generator in internal mode
// RQ9 - host holds reset input low at least 50 ms each time
// RQ10 - all registers back at defaults within 100 us of reset rise
// RQ11 - no register access during the 100 us after reset rise
// RQ12 - display memory cleared to 00H within 20 us of reset rise
// RQ13 - system clock repeated on the clock repeat output; the code toggles it each cycle, giving the system clock divided by two
// RQ14 - internal timing generator free-runs regardless of video input
// RQ15 - counts run on system clock; pins resynchronised before use
`include "osd_defines.svh"
module osd_pin_level_control
  import osd_pkg::*;
#(
  parameter int FRAME_PULSE_CYCLES = `FRAME_PULSE_LINES * `LINE_CYC
) (
  input wire logic clock, // system clock
  input wire logic rst, // synchronous reset, active high
  input wire logic reset_pin_n, // host reset input, active low
  input wire logic spi_sclk, // serial clock from host
  input wire logic spi_cs_n, // chip select, active low
  input wire logic serial_in, // serial data from host
  input wire logic video_in, // sliced video sync, low in sync
  output logic serial_out, // serial data to host
  output logic serial_out_oe, // serial output drive enable
  output logic sync_lost_flag_o, // open-drain level, always low
  output logic sync_lost_flag_oe, // pulls flag low while sync present
  output logic frame_sync_n_o, // open-drain level, always low
  output logic frame_sync_n_oe, // pulls frame sync low
  output logic line_sync_n_o, // open-drain level, always low
  output logic line_sync_n_oe, // pulls line sync low
  output logic clock_repeat_out // system clock divided by two
);
  localparam int IDX_RST = 0;
  localparam int IDX_SCLK = 1;
  localparam int IDX_CS = 2;
  localparam int IDX_SDI = 3;
  localparam int IDX_VID = 4;

  spi_link_if lnk();
  logic [4:0] sync1_reg;
  logic [4:0] sync2_reg;
  phase_t phase_reg;
  phase_t phase_next;
  logic [11:0] phase_cnt_reg;
  logic [8:0] clr_addr_reg;
  byte_t mode_reg;
  logic [8:0] addr_reg;
  byte_t rd_latch_reg;
  logic cur_write_reg;
  logic [6:0] cur_index_reg;
  byte_t mem [0:`MEM_DEPTH-1];
  logic vid_prev_reg;
  logic [9:0] low_cnt_reg;
  logic [11:0] win_cnt_reg;
  logic [5:0] miss_cnt_reg;
  logic [5:0] good_cnt_reg;
  logic lost_reg;
  logic [7:0] line_cnt_reg;
  logic [12:0] frame_cnt_reg;
  logic [11:0] gen_h_reg;
  logic [8:0] gen_line_reg;
  logic serial_out_reg;
  logic serial_oe_reg;
  logic lost_oe_reg;
  logic frame_oe_reg;
  logic line_oe_reg;
  logic od_low_reg;
  logic repeat_reg;

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  // every outside input passes two flops before use
  always_ff @(posedge clock) begin
    if (rst) begin
      sync1_reg <= 5'h1F;
      sync2_reg <= 5'h1F;
    end else begin
      sync1_reg <= {video_in, serial_in, spi_cs_n, spi_sclk, reset_pin_n};
      sync2_reg <= sync1_reg; // [RQ15]
    end
  end

  wire pin_rst_n = sync2_reg[IDX_RST];
  wire vid = sync2_reg[IDX_VID];
  assign lnk.sclk = sync2_reg[IDX_SCLK];
  assign lnk.cs_n = sync2_reg[IDX_CS];
  assign lnk.sdi = sync2_reg[IDX_SDI];

  spi_shift_engine u_engine (
    .clock(clock),
    .rst(rst),
    .lnk(lnk.engine)
  );

  // ************************************************************
  // reset sequencing
  // ************************************************************
  // hold while pin low, clear memory, then wait out the lockout
  always_comb begin
    phase_next = phase_reg;
    case (phase_reg)
      PH_HOLD: if (pin_rst_n) phase_next = PH_CLEAR;
      PH_CLEAR: if (clr_addr_reg == 9'(`MEM_DEPTH - 1)) phase_next = PH_WAIT;
      PH_WAIT: begin
        if (phase_cnt_reg >= 12'(`REG_ACCESS_CYC - 1)) phase_next = PH_RUN;
      end
      PH_RUN: phase_next = PH_RUN;
      default: phase_next = PH_HOLD;
    endcase
    if (!pin_rst_n) phase_next = PH_HOLD; // [RQ9]
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      phase_reg <= PH_HOLD;
      phase_cnt_reg <= 12'h000;
      clr_addr_reg <= 9'h000;
    end else begin
      phase_reg <= phase_next;
      phase_cnt_reg <= (phase_reg == PH_HOLD) ? 12'h000 :
        (phase_cnt_reg == 12'hFFF) ? phase_cnt_reg : phase_cnt_reg + 12'h001;
      clr_addr_reg <= (phase_reg == PH_CLEAR) ? clr_addr_reg + 9'h001 :
        9'h000; // [RQ12]
    end
  end

  // ************************************************************
  // register access
  // ************************************************************
  wire access_ok = (phase_reg == PH_RUN); // [RQ11]
  wire do_write = lnk.wr_pulse && cur_write_reg && access_ok;
  wire [6:0] cmd_index = lnk.cmd_byte[6:0];
  wire [8:0] addr_step = (addr_reg == 9'(`MEM_DEPTH - 1)) ? 9'h000 :
    addr_reg + 9'h001;
  wire [7:0] mem_word = (addr_reg < 9'(`MEM_DEPTH)) ? mem[addr_reg] : 8'h00;
  wire [7:0] rd_sel =
    (cmd_index == `REG_MODE) ? mode_reg :
    (cmd_index == `REG_ADDR_LO) ? addr_reg[7:0] :
    (cmd_index == `REG_ADDR_HI) ? {7'h00, addr_reg[8]} :
    (cmd_index == `REG_DATA) ? mem_word :
    (cmd_index == `REG_STATUS) ? {7'h00, lost_reg} : 8'h00;

  // command decode, read latch and register writes
  always_ff @(posedge clock) begin
    if (rst || phase_reg == PH_HOLD) begin
      mode_reg <= `MODE_RESET; // [RQ10]
      addr_reg <= 9'h000;
      rd_latch_reg <= 8'h00;
      cur_write_reg <= 1'b0;
      cur_index_reg <= 7'h00;
    end else begin
      if (lnk.cmd_pulse) begin
        cur_write_reg <= ~lnk.cmd_byte[`CMD_READ_BIT];
        cur_index_reg <= cmd_index;
        rd_latch_reg <= access_ok ? rd_sel : 8'h00; // [RQ11]
      end
      if (do_write) begin
        case (cur_index_reg)
          `REG_MODE: mode_reg <= lnk.wr_byte;
          `REG_ADDR_LO: addr_reg[7:0] <= lnk.wr_byte;
          `REG_ADDR_HI: addr_reg[8] <= lnk.wr_byte[0];
          `REG_DATA: addr_reg <= addr_step;
          default: addr_reg <= addr_reg;
        endcase
      end
    end
  end
  assign lnk.rd_byte = rd_latch_reg;

  // display memory: cleared after reset, then written from the port
  always_ff @(posedge clock) begin
    if (phase_reg == PH_CLEAR) begin
      mem[clr_addr_reg] <= `MEM_CLEAR_VALUE; // [RQ12]
    end else if (do_write && cur_index_reg == `REG_DATA) begin
      mem[addr_reg] <= lnk.wr_byte;
    end
  end

  // ************************************************************
  // loss-of-sync detector
  // ************************************************************
  wire sync_fall = vid_prev_reg & ~vid;
  wire sync_rise = ~vid_prev_reg & vid;
  wire timeout = ~sync_fall && win_cnt_reg == 12'(`LINE_WINDOW_CYC - 1);
  wire broad = sync_rise && low_cnt_reg >= 10'(`BROAD_MIN_CYC);
  wire good_full = sync_fall && good_cnt_reg >= 6'(`SYNC_RUN_LINES - 1);
  wire miss_full = timeout && miss_cnt_reg >= 6'(`SYNC_RUN_LINES - 1);

  // counts line windows and runs of present or missing sync
  always_ff @(posedge clock) begin
    if (rst) begin
      vid_prev_reg <= 1'b1;
      low_cnt_reg <= 10'h000;
      win_cnt_reg <= 12'h000;
      miss_cnt_reg <= 6'h00;
      good_cnt_reg <= 6'h00;
      lost_reg <= 1'b1;
    end else begin
      vid_prev_reg <= vid;
      low_cnt_reg <= vid ? 10'h000 :
        (low_cnt_reg == 10'h3FF) ? low_cnt_reg : low_cnt_reg + 10'h001;
      if (sync_fall) begin
        win_cnt_reg <= 12'h000;
        miss_cnt_reg <= 6'h00;
        good_cnt_reg <= inc_sat(good_cnt_reg);
      end else if (timeout) begin
        win_cnt_reg <= 12'h000;
        good_cnt_reg <= 6'h00;
        miss_cnt_reg <= inc_sat(miss_cnt_reg);
      end else begin
        win_cnt_reg <= win_cnt_reg + 12'h001;
      end
      if (miss_full) lost_reg <= 1'b1; // [RQ4]
      else if (good_full) lost_reg <= 1'b0; // [RQ5]
    end
  end

  // ************************************************************
  // sync outputs
  // ************************************************************
  wire int_mode = mode_reg[`MODE_INT_BIT];
  wire gen_line_start = (gen_h_reg == 12'h000);
  wire line_trig = int_mode ? gen_line_start : (sync_rise && !lost_reg);
  wire frame_trig = (frame_cnt_reg == 13'h0000) && (int_mode ?
    (gen_line_start && gen_line_reg == 9'h000) : (broad && !lost_reg));

  // free-running generator, pulse stretchers and output flops
  always_ff @(posedge clock) begin
    if (rst) begin
      gen_h_reg <= 12'h000;
      gen_line_reg <= 9'h000;
      line_cnt_reg <= 8'h00;
      frame_cnt_reg <= 13'h0000;
    end else begin
      gen_h_reg <= (gen_h_reg == 12'(`LINE_CYC - 1)) ? 12'h000 :
        gen_h_reg + 12'h001; // [RQ14]
      if (gen_h_reg == 12'(`LINE_CYC - 1)) begin
        gen_line_reg <= (gen_line_reg == 9'(`FIELD_LINES - 1)) ? 9'h000 :
          gen_line_reg + 9'h001;
      end
      line_cnt_reg <= line_trig ? 8'(`LINE_PULSE_CYC) : // [RQ7] [RQ8]
        (line_cnt_reg != 8'h00) ? line_cnt_reg - 8'h01 : 8'h00;
      frame_cnt_reg <= frame_trig ? 13'(FRAME_PULSE_CYCLES) : // [RQ6]
        (frame_cnt_reg != 13'h0000) ? frame_cnt_reg - 13'h0001 : 13'h0000;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      serial_out_reg <= 1'b0;
      serial_oe_reg <= 1'b0;
      lost_oe_reg <= 1'b0;
      frame_oe_reg <= 1'b0;
      line_oe_reg <= 1'b0;
      od_low_reg <= 1'b0;
      repeat_reg <= 1'b0;
    end else begin
      serial_out_reg <= lnk.sdo & ~lnk.cs_n; // [RQ3]
      serial_oe_reg <= ~lnk.cs_n; // [RQ1]
      lost_oe_reg <= ~lost_reg;
      frame_oe_reg <= (frame_cnt_reg != 13'h0000); // [RQ6]
      line_oe_reg <= (line_cnt_reg != 8'h00); // [RQ7]
      od_low_reg <= 1'b0;
      repeat_reg <= ~repeat_reg; // [RQ13]
    end
  end

  assign serial_out = serial_out_reg;
  assign serial_out_oe = serial_oe_reg;
  assign sync_lost_flag_o = od_low_reg;
  assign sync_lost_flag_oe = lost_oe_reg;
  assign frame_sync_n_o = od_low_reg;
  assign frame_sync_n_oe = frame_oe_reg;
  assign line_sync_n_o = od_low_reg;
  assign line_sync_n_oe = line_oe_reg;
  assign clock_repeat_out = repeat_reg;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  sequence s_flag_high;
    lost_reg ##1 !sync_lost_flag_oe;
  endsequence
  sequence s_flag_low;
    !lost_reg ##1 sync_lost_flag_oe;
  endsequence
  sequence s_line_low;
    line_cnt_reg == 8'(`LINE_PULSE_CYC) ##1 line_sync_n_oe;
  endsequence

  a_sdo_float: assert property (lnk.cs_n |=> !serial_out_oe) // [RQ1]
    else $error("serial output driven while deselected");
  a_lost_raise: assert property (miss_full |=> s_flag_high) // [RQ4]
    else $error("loss flag not raised after missing sync run");
  a_lost_drop: assert property (good_full |=> s_flag_low) // [RQ5]
    else $error("loss flag not dropped after sync run");
  a_lost_hold: assert property (lost_reg && !good_full |=> lost_reg) // [RQ5]
    else $error("loss flag dropped early");
  a_line_pulse: assert property (line_trig |=> s_line_low) // [RQ7]
    else $error("line sync not pulled low");
  a_frame_pulse: assert property (frame_trig |-> ##2 frame_sync_n_oe) // [RQ6]
    else $error("frame sync not pulled low");
  a_ext_gated: assert property (!int_mode && lost_reg |-> !line_trig) // [RQ8]
    else $error("line sync from absent video");
  a_gen_wrap: assert property (gen_h_reg == 12'(`LINE_CYC - 1)
    |=> gen_h_reg == 12'h000) // [RQ14]
    else $error("timing generator line length wrong");
  a_mem_clear: assert property (phase_reg == PH_CLEAR
    |-> phase_cnt_reg < 12'(`MEM_CLEAR_CYC)) // [RQ12]
    else $error("memory clear overran its time");
  a_reg_block: assert property (lnk.wr_pulse && !access_ok
    |=> $stable(mode_reg) || phase_reg == PH_HOLD) // [RQ11]
    else $error("register written during lockout");
  a_reg_ready: assert property (phase_reg == PH_WAIT && pin_rst_n &&
    phase_cnt_reg == 12'(`REG_ACCESS_CYC - 1) |=> access_ok) // [RQ10]
    else $error("registers not released on time");
  a_clock_repeat: assert property (1'b1 |=> clock_repeat_out !=
    $past(clock_repeat_out)) // [RQ13]
    else $error("clock repeat output stalled");
endmodule

// ==== osd_pkg.sv ====
package osd_pkg;
  // reset sequencing phases
  typedef enum logic [3:0] {
    PH_HOLD = 4'b0001,
    PH_CLEAR = 4'b0010,
    PH_WAIT = 4'b0100,
    PH_RUN = 4'b1000
  } phase_t;

  typedef logic [7:0] byte_t;

  // saturating run counter step
  function automatic logic [5:0] inc_sat(input logic [5:0] v);
    return (v == 6'h3F) ? v : v + 6'h01;
  endfunction
endpackage

// ==== spi_link_if.sv ====
`timescale 1ns/1ps
interface spi_link_if;
  logic sclk;
  logic cs_n;
  logic sdi;
  logic sdo;
  logic cmd_pulse;
  logic wr_pulse;
  logic [7:0] cmd_byte;
  logic [7:0] wr_byte;
  logic [7:0] rd_byte;
  modport engine(input sclk, cs_n, sdi, rd_byte,
    output sdo, cmd_pulse, wr_pulse, cmd_byte, wr_byte);
  modport core(output sclk, cs_n, sdi, rd_byte,
    input sdo, cmd_pulse, wr_pulse, cmd_byte, wr_byte);
endinterface

// ==== spi_shift_engine.sv ====
`timescale 1ns/1ps
module spi_shift_engine
  import osd_pkg::*;
(
  input wire logic clock, // system clock
  input wire logic rst, // synchronous reset
  spi_link_if.engine lnk // synchronised serial pins and frames
);
  logic sclk_prev_reg;
  logic [3:0] cnt_reg;
  logic [7:0] shift_reg;
  logic sdo_reg;
  logic cmd_pulse_reg;
  logic wr_pulse_reg;
  byte_t cmd_byte_reg;
  byte_t wr_byte_reg;
  wire rise = lnk.sclk & ~sclk_prev_reg & ~lnk.cs_n;
  wire fall = ~lnk.sclk & sclk_prev_reg & ~lnk.cs_n;
  wire [7:0] shifted = {shift_reg[6:0], lnk.sdi};

  // ************************************************************
  // shift engine
  // ************************************************************
  // input bits taken on sclk rise, output bits moved on sclk fall
  always_ff @(posedge clock) begin
    if (rst) begin
      sclk_prev_reg <= 1'b0;
      cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      sdo_reg <= 1'b0;
      cmd_pulse_reg <= 1'b0;
      wr_pulse_reg <= 1'b0;
      cmd_byte_reg <= 8'h00;
      wr_byte_reg <= 8'h00;
    end else begin
      sclk_prev_reg <= lnk.sclk;
      cmd_pulse_reg <= rise && cnt_reg == 4'h7; // [RQ2]
      wr_pulse_reg <= rise && cnt_reg == 4'hF; // [RQ2]
      if (lnk.cs_n) begin
        cnt_reg <= 4'h0;
        sdo_reg <= 1'b0;
      end else if (rise) begin
        shift_reg <= shifted; // [RQ2]
        cnt_reg <= cnt_reg + 4'h1;
        if (cnt_reg == 4'h7) cmd_byte_reg <= shifted;
        if (cnt_reg == 4'hF) wr_byte_reg <= shifted;
      end else if (fall) begin
        sdo_reg <= cnt_reg[3] & lnk.rd_byte[~cnt_reg[2:0]]; // [RQ3]
      end
    end
  end

  assign lnk.sdo = sdo_reg;
  assign lnk.cmd_pulse = cmd_pulse_reg;
  assign lnk.wr_pulse = wr_pulse_reg;
  assign lnk.cmd_byte = cmd_byte_reg;
  assign lnk.wr_byte = wr_byte_reg;

  // ************************************************************
  // checks
  // ************************************************************
  a_cmd_capture: assert property (@(posedge clock) disable iff (rst)
    rise && cnt_reg == 4'h7 |=> cmd_pulse_reg && // [RQ2]
      cmd_byte_reg[0] == $past(lnk.sdi))
    else $error("command byte not taken on sclk rise");
  a_sdo_on_fall: assert property (@(posedge clock) disable iff (rst)
    $changed(sdo_reg) |-> $past(fall) || $past(lnk.cs_n)) // [RQ3]
    else $error("serial output moved away from sclk fall");
endmodule

// ==== tb.sv ====
`timescale 1ns/1ps
// ************************************************************
// testbench for the pin level control block
// ************************************************************
`define CHECK(nm, exp, got) \
  begin \
    checked++; \
    if ((got) !== (exp)) begin \
      error_cnt++; \
      $display("unexpected %s expected %h seen %h", nm, exp, got); \
    end \
  end

module tb;
  logic clock, rst, reset_pin_n, spi_sclk, spi_cs_n, serial_in;
  logic video_in, serial_out, serial_out_oe, sync_lost_flag_o;
  logic sync_lost_flag_oe, frame_sync_n_o, frame_sync_n_oe;
  logic line_sync_n_o, line_sync_n_oe, clock_repeat_out;
  int error_cnt = 0;
  int checked = 0;
  logic [7:0] rd;
  logic oe_all;
  logic prev;
  int n;

  osd_pin_level_control #(.FRAME_PULSE_CYCLES(20)) uut (
    .clock(clock), .rst(rst), .reset_pin_n(reset_pin_n),
    .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .serial_in(serial_in),
    .video_in(video_in), .serial_out(serial_out),
    .serial_out_oe(serial_out_oe), .sync_lost_flag_o(sync_lost_flag_o),
    .sync_lost_flag_oe(sync_lost_flag_oe),
    .frame_sync_n_o(frame_sync_n_o), .frame_sync_n_oe(frame_sync_n_oe),
    .line_sync_n_o(line_sync_n_o), .line_sync_n_oe(line_sync_n_oe),
    .clock_repeat_out(clock_repeat_out));

  host_port_model host (
    .clock(clock), .sdo(serial_out), .sdo_oe(serial_out_oe),
    .reset_pin_n(reset_pin_n), .spi_sclk(spi_sclk),
    .spi_cs_n(spi_cs_n), .serial_in(serial_in));

  // 40 MHz system clock
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic final_report();
    if (error_cnt == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // one sync pulse of the sliced video
  task automatic sync_pulse(input int low, input int high);
    video_in = 1'b0;
    repeat (low) @(negedge clock);
    video_in = 1'b1;
    repeat (high) @(negedge clock);
  endtask

  task automatic t_after_reset();
    `CHECK("oe idle", 1'b0, serial_out_oe)
    `CHECK("lost after reset", 1'b0, sync_lost_flag_oe)
    prev = clock_repeat_out;
    @(negedge clock);
    `CHECK("clock repeat", ~prev, clock_repeat_out)
  endtask

  task automatic t_lockout();
    host.pulse_reset(10);
    host.xfer(8'h84, 8'h00, rd, oe_all);
    `CHECK("locked read", 8'h00, rd)
    `CHECK("oe in frame", 1'b1, oe_all)
    repeat (5) @(negedge clock);
    `CHECK("oe after frame", 1'b0, serial_out_oe)
    repeat (4010) @(negedge clock);
    host.xfer(8'h84, 8'h00, rd, oe_all);
    `CHECK("status read", 8'h01, rd)
    host.xfer(8'h80, 8'h00, rd, oe_all);
    `CHECK("mode default", 8'h00, rd)
  endtask

  // display memory: cleared word, write with address step, readback
  task automatic t_memory();
    host.xfer(8'h83, 8'h00, rd, oe_all);
    `CHECK("cleared memory", 8'h00, rd)
    host.xfer(8'h01, 8'h05, rd, oe_all);
    host.xfer(8'h03, 8'hA5, rd, oe_all);
    host.xfer(8'h81, 8'h00, rd, oe_all);
    `CHECK("address step", 8'h06, rd)
    host.xfer(8'h01, 8'h05, rd, oe_all);
    host.xfer(8'h83, 8'h00, rd, oe_all);
    `CHECK("memory readback", 8'hA5, rd)
  endtask

  task automatic t_internal_sync();
    host.xfer(8'h00, 8'h01, rd, oe_all);
    host.xfer(8'h80, 8'h00, rd, oe_all);
    `CHECK("mode readback", 8'h01, rd)
    n = 0;
    while (line_sync_n_oe !== 1'b1 && n < 3000) begin
      @(negedge clock);
      n++;
    end
    `CHECK("internal line sync", 1'b1, line_sync_n_oe)
    if (n >= 3000) final_report();
    host.xfer(8'h00, 8'h00, rd, oe_all);
    `CHECK("lost in internal", 1'b0, sync_lost_flag_oe)
  endtask

  task automatic t_sync_gain();
    repeat (31) sync_pulse(40, 360);
    `CHECK("lost after 31", 1'b0, sync_lost_flag_oe)
    video_in = 1'b0;
    repeat (10) @(negedge clock);
    `CHECK("found after 32", 1'b1, sync_lost_flag_oe)
    repeat (30) @(negedge clock);
    video_in = 1'b1;
    repeat (8) @(negedge clock);
    `CHECK("line sync", 1'b1, line_sync_n_oe)
    `CHECK("no frame sync", 1'b0, frame_sync_n_oe)
    repeat (350) @(negedge clock);
    `CHECK("line sync end", 1'b0, line_sync_n_oe)
  endtask

  task automatic t_frame_sync();
    video_in = 1'b0;
    repeat (420) @(negedge clock);
    video_in = 1'b1;
    repeat (8) @(negedge clock);
    `CHECK("frame sync", 1'b1, frame_sync_n_oe)
    repeat (30) @(negedge clock);
    `CHECK("frame sync end", 1'b0, frame_sync_n_oe)
  endtask

  task automatic t_sync_loss();
    repeat (30 * 3200) @(negedge clock);
    `CHECK("still found", 1'b1, sync_lost_flag_oe)
    n = 0;
    while (sync_lost_flag_oe !== 1'b0 && n < 3 * 3200) begin
      @(negedge clock);
      n++;
    end
    `CHECK("lost after 32", 1'b0, sync_lost_flag_oe)
    if (n >= 3 * 3200) final_report();
    sync_pulse(40, 8);
    `CHECK("ignored while lost", 1'b0, line_sync_n_oe)
  endtask

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    rst = 1'b1;
    video_in = 1'b1;
    repeat (6) @(negedge clock);
    rst = 1'b0;
    repeat (2) @(negedge clock);
    t_after_reset();
    t_lockout();
    t_memory();
    t_internal_sync();
    t_sync_gain();
    t_frame_sync();
    t_sync_loss();
    final_report();
  end
endmodule
